// ===== verif/csg_chk_sva.sv
// csg_chk_sva: concurrent checks on the signals of csg_if
// assumes one clock, synchronous active-low reset, no second reset mid-run
`timescale 1ns/1ps
module csg_chk
  import csg_pkg::*;
(
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  // interface signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       nmi,
  input wire logic       ce_4x,
  input wire logic       ce_2x,
  input wire logic       ce_cpu
);
  logic [2:0] win_r;
  logic       fd_r;
  logic       lock_r;
  logic       sel_r;
  logic       pwr;
  logic       lock_eff;

  // protected write: only inside the window, first one closes it
  assign pwr = wr && (win_r != 3'h0) && (addr == OFF_SYS_SEL || addr == OFF_PRESCALE ||
               addr == OFF_LOCK || addr == OFF_FAIL_DET);
  // the lock drops in the same cycle as the failure pulse
  assign lock_eff = lock_r && !nmi;

  // shadow of window, sticky detector enable, lock and select history
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      win_r  <= 3'h0;
      fd_r   <= 1'b0;
      lock_r <= 1'b0;
      sel_r  <= 1'b0;
    end else begin
      if (wr && addr == OFF_CHG_PROT && wdata == CCP_SIGNATURE) begin
        win_r <= CCP_OPEN_CYC;
      end else if (pwr) begin
        win_r <= 3'h0;
      end else if (win_r != 3'h0) begin
        win_r <= win_r - 3'h1;
      end
      if (pwr && addr == OFF_FAIL_DET && wdata[0]) begin
        fd_r <= 1'b1;
      end
      if (nmi) begin
        lock_r <= 1'b0;
      end else if (pwr && addr == OFF_LOCK && wdata[0]) begin
        lock_r <= 1'b1;
      end
      if (pwr && addr == OFF_SYS_SEL) begin
        sel_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  property p_rdata_idle; !rd |=> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside answer");
  property p_nmi_pulse; nmi |=> !nmi; endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("failure interrupt longer than one cycle");
  property p_nmi_needs_fd; nmi |-> fd_r; endproperty
  a_nmi_needs_fd: assert property (p_nmi_needs_fd) else $error("interrupt with detector off");
  property p_cpu_in_2x; ce_cpu |-> ce_2x && ce_4x; endproperty
  a_cpu_in_2x: assert property (p_cpu_in_2x) else $error("cpu tick not aligned to fast ticks");
  property p_2x_in_4x; ce_2x |-> ce_4x; endproperty
  a_2x_in_4x: assert property (p_2x_in_4x) else $error("2x tick without 4x tick");
  property p_lock_read; rd && addr == OFF_LOCK |=> rdata[0] == $past(lock_eff); endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock bit wrong");
  property p_sel_reset; rd && addr == OFF_SYS_SEL && !sel_r |=> rdata == 8'h00; endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select moved without protected write");
  property p_fd_read; rd && addr == OFF_FAIL_DET |=> rdata[0] == $past(fd_r); endproperty
  a_fd_read: assert property (p_fd_read) else $error("detector enable wrong");
endmodule

// ===== verif/csg_clk_gen_tb.sv
// csg_clk_gen_tb: both ends joined by csg_if, driven from the software port
// assumes oscillators are tick pulses off a free counter; crystal can be stopped
`timescale 1ns/1ps
module csg_clk_gen_tb;
  import csg_pkg::*;
  logic       clk_sys    = 1'b0;
  logic       reset_n    = 1'b0;
  logic [7:0] sw_addr    = 8'h00;
  logic [7:0] sw_wdata   = 8'h00;
  logic       sw_wr      = 1'b0;
  logic       sw_rd      = 1'b0;
  logic [3:0] osc_tick   = 4'h0;
  logic [3:0] osc_stable = 4'h7;
  logic       pll_tick   = 1'b0;
  logic       ulp_tick   = 1'b0;
  logic       xtal_alive = 1'b1;
  logic [7:0] tcnt       = 8'h00;
  csg_sleep_t sleep_mode = CSG_SLP_ACTIVE;
  logic       rtc_en     = 1'b0;
  logic [7:0] sw_rdata;
  logic       int_block;
  logic       nmi_pend;
  logic [4:0] osc_run;
  logic [4:0] pll_factor;
  int         bad_count  = 0;
  int         num_checks = 0;
  int         c4;
  int         ccpu;
  csg_if bus ();

  csg_clk_gen i_csg_clk_gen (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(1'b1), .bus(bus.dev),
    .i_osc_tick(osc_tick), .i_osc_stable(osc_stable), .i_pll_tick(pll_tick), .i_ulp_tick(ulp_tick),
    .o_osc_run(osc_run), .o_pll_factor(pll_factor), .i_sleep_mode(sleep_mode), .i_rtc_en(rtc_en));
  csg_cpu_side i_csg_cpu_side (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(1'b1), .i_sw_addr(sw_addr),
    .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata), .o_int_block(int_block),
    .o_nmi_pend(nmi_pend), .bus(bus.host));
  csg_chk i_csg_chk (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
    .rd(bus.rd), .rdata(bus.rdata), .nmi(bus.nmi), .ce_4x(bus.ce_4x), .ce_2x(bus.ce_2x), .ce_cpu(bus.ce_cpu));

  always #5 clk_sys = ~clk_sys;

  // rc2m and crystal every 4th cycle, r32m every 2nd; crystal well above the fail threshold
  always @(posedge clk_sys) begin
    tcnt     <= tcnt + 8'h01;
    osc_tick <= {xtal_alive && tcnt[1:0] == 2'h0, tcnt[0], tcnt[2:0] == 3'h0, tcnt[1:0] == 2'h0};
    pll_tick <= tcnt[0];
    ulp_tick <= tcnt[3:0] == 4'h0;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // leading edge wait keeps strobes one cycle apart
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    chk(sw_rdata & m, e);
  endtask
  task automatic sig;
    wr_reg(OFF_CHG_PROT, CCP_SIGNATURE);
  endtask
  task automatic count(input int n);
    c4   = 0;
    ccpu = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (bus.ce_4x === 1'b1) c4++;
      if (bus.ce_cpu === 1'b1) ccpu++;
    end
  endtask
  // bounded wait for the detector to react
  task automatic wait_nmi;
    for (int k = 0; k < 200 && nmi_pend !== 1'b1; k++) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset;
    rd_chk(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h1f, 8'h01);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h01, 8'h01);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h00);
    rd_chk(OFF_PRESCALE, 8'h3f, 8'h00);
    rd_chk(OFF_FAIL_DET, 8'h01, 8'h00);
    rd_chk(8'h20, 8'hff, 8'h00);
    chk({3'h0, pll_factor}, 8'h01);
    count(64);
    chk(8'(c4), 8'h10);
    chk(8'(ccpu), 8'h10);
    $display("test reset done");
  endtask

  task automatic t_pll;
    wr_reg(OFF_XOSC_CTRL, 8'h01);
    wr_reg(OFF_PLL_CTRL, 8'h83);
    rd_chk(OFF_PLL_CTRL, 8'hdf, 8'h03);
    wr_reg(OFF_XOSC_CTRL, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr_reg(OFF_PLL_CTRL, {2'(r), 6'h04});
      rd_chk(OFF_PLL_CTRL, 8'hdf, {2'(r), 6'h04});
    end
    wr_reg(OFF_PLL_CTRL, 8'h05);
    wr_reg(OFF_PLL_CTRL, 8'h00);
    chk({3'h0, pll_factor}, 8'h05);
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h11);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h10, 8'h00);
    wr_reg(OFF_PLL_CTRL, 8'h09);
    chk({3'h0, pll_factor}, 8'h05);
    repeat (220) @(posedge clk_sys);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h10, 8'h00);
    repeat (50) @(posedge clk_sys);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h10, 8'h10);
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h01);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h10, 8'h00);
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h11);
    rd_chk(OFF_OSCILLATOR_STATUS_REGISTER, 8'h10, 8'h00);
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h01);
    $display("test pll done");
  endtask

  task automatic t_sel;
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h0d);
    sig;
    wr_reg(OFF_SYS_SEL, 8'h03);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h00);
    wr_reg(OFF_SYS_SEL, 8'h02);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h00);
    sig;
    chk({7'h0, int_block}, 8'h01);
    wr_reg(OFF_SYS_SEL, 8'h02);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h02);
    sig;
    wr_reg(OFF_SYS_SEL, 8'h00);
    wr_reg(OFF_PRESCALE, 8'h06);
    rd_chk(OFF_PRESCALE, 8'h3f, 8'h00);
    sig;
    wr_reg(OFF_PRESCALE, 8'h06);
    rd_chk(OFF_PRESCALE, 8'h3f, 8'h06);
    // the new b/c split lands only after up to four prescaler a periods
    count(40);
    count(64);
    chk(8'(c4), 8'h08);
    chk(8'(ccpu), 8'h02);
    $display("test select done");
  endtask

  task automatic t_fail;
    @(posedge clk_sys);
    osc_stable <= 4'hf;
    sig;
    wr_reg(OFF_SYS_SEL, 8'h03);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h03);
    sig;
    wr_reg(OFF_LOCK, 8'h01);
    sig;
    wr_reg(OFF_PRESCALE, 8'h00);
    rd_chk(OFF_PRESCALE, 8'h3f, 8'h06);
    sig;
    wr_reg(OFF_FAIL_DET, 8'h01);
    rd_chk(OFF_FAIL_DET, 8'h01, 8'h01);
    repeat (100) @(posedge clk_sys);
    chk({7'h0, nmi_pend}, 8'h00);
    xtal_alive <= 1'b0;
    wait_nmi;
    chk({7'h0, nmi_pend}, 8'h01);
    chk({7'h0, osc_run[B_XOSC]}, 8'h00);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h00);
    rd_chk(OFF_LOCK, 8'h01, 8'h00);
    rd_chk(OFF_FAIL_DET, 8'h03, 8'h03);
    wr_reg(OFF_HOST_STAT, 8'h01);
    xtal_alive <= 1'b1;
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h0d);
    repeat (40) @(posedge clk_sys);
    chk({7'h0, nmi_pend}, 8'h00);
    xtal_alive <= 1'b0;
    wait_nmi;
    chk({7'h0, nmi_pend}, 8'h01);
    chk({7'h0, osc_run[B_XOSC]}, 8'h00);
    rd_chk(OFF_SYS_SEL, 8'h07, 8'h00);
    $display("test failure done");
  endtask

  task automatic t_sleep;
    @(posedge clk_sys);
    sleep_mode <= CSG_SLP_IDLE;
    count(8);
    count(64);
    chk(8'(c4), 8'h08);
    chk({3'h0, osc_run}, 8'h05);
    @(posedge clk_sys);
    sleep_mode <= CSG_SLP_PWRDOWN;
    count(8);
    count(64);
    chk(8'(c4), 8'h00);
    chk({3'h0, osc_run}, 8'h00);
    // power-save with the counter on keeps only the rc32k source alive
    wr_reg(OFF_OSCILLATOR_CONTROL_REGISTER, 8'h07);
    @(posedge clk_sys);
    rtc_en     <= 1'b1;
    sleep_mode <= CSG_SLP_PWRSAVE;
    count(8);
    chk({3'h0, osc_run}, 8'h02);
    @(posedge clk_sys);
    sleep_mode <= CSG_SLP_ACTIVE;
    $display("test sleep done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // whole run needs about 1000 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_pll;
    t_sel;
    t_fail;
    t_sleep;
    stop_test;
  end
endmodule

// ===== verilog/csg_clk_gen.sv
// csg_clk_gen: clock generator control, pll sequencing, prescalers, protection, lock, fail detect
// assumes oscillator ticks and stable levels come from analog cells, synchronous to i_clk_sys
//
// Overview of operation
// - pll multiplies reference by 1 to 31
// - pll reference: rc2m, r32m/4, crystal, external clock
// - crystal refused as reference in watch mode
// - software programs pll, enables, polls ready
// - pll ready after 64 reference cycles
// - pll config writes ignored while enabled
// - software keeps pll input/output frequency limits
// - mux picks source; prescaler a 1..512
// - prescalers b,c divide up to four combined
// - reset: rc2m, all prescalers undivided
// - prescaler changes take effect glitch free
// - switch to unstable source rejected
// - signature 0xd8 opens protected write, masks interrupts
// - one protected update per signature
// - lock bit freezes source select and prescalers until reset or failure
// - detected failure releases the lock
// - powerdown/powersave stop oscillators, rtc source excepted in powersave
// - idle/standby keep oscillators running
// - failing system source falls back, nmi
// - failing non-system source disabled, nmi
// - ulp monitor declares failure below 32 khz
// - fail detector off at reset, sticky enable
// - per-oscillator enable and ready flag
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module csg_clk_gen (
  // clock, reset, enable
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  // cpu-side register port and clock enables
  csg_if.dev                     bus,
  // analog oscillator side
  input  wire logic [3:0]        i_osc_tick,
  input  wire logic [3:0]        i_osc_stable,
  input  wire logic              i_pll_tick,
  input  wire logic              i_ulp_tick,
  output logic      [4:0]        o_osc_run,
  output logic      [4:0]        o_pll_factor,
  // power management
  input  wire csg_pkg::csg_sleep_t i_sleep_mode,
  input  wire logic              i_rtc_en
);
  import csg_pkg::*;

  logic [4:0]   osc_en_r;
  logic [4:0]   osc_rdy;
  logic         watch_mode_r;
  logic         fd_en_r;
  logic         fd_flag_r;
  logic [4:0]   pll_multiply_factor_r;
  csg_pll_ref_t pll_ref_r;
  logic [6:0]   pll_cnt_r;
  logic [1:0]   r32m_div_r;
  logic         ref_tick;
  csg_sys_src_t sys_sel_r;
  logic [3:0]   psa_req_r;
  logic [3:0]   psa_act_r;
  logic [1:0]   pbc_req_r;
  logic [1:0]   pbc_act_r;
  logic [8:0]   pa_cnt_r;
  logic [1:0]   bc_cnt_r;
  logic         lock_r;
  logic [2:0]   ccp_cnt_r;
  logic [1:0]   fd_miss_r;
  logic         fd_seen_r;
  logic         fail_evt;
  logic         stop_all;
  logic         sys_tick;
  logic         wr_prot;
  logic         wr_en;

  // helper: is the write aimed at this offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // prescaler a divide count minus one from its power-of-two code
  function automatic logic [8:0] psa_last(input logic [3:0] code);
    psa_last = 9'((10'h001 << code) - 10'h001);
  endfunction

  assign wr_en    = bus.wr && i_clk_en;
  assign wr_prot  = wr_en && (ccp_cnt_r != 3'h0);
  assign stop_all = (i_sleep_mode == CSG_SLP_PWRDOWN) ||
                    (i_sleep_mode == CSG_SLP_PWRSAVE);
  assign fail_evt = fd_en_r && osc_en_r[B_XOSC] && (fd_miss_r == FD_MISS_LIMIT);

  // ready flags: oscillator enabled, running and reported stable
  always_comb begin
    osc_rdy        = osc_en_r & {1'b0, i_osc_stable} & {5{~stop_all}};
    osc_rdy[B_PLL] = osc_en_r[B_PLL] && (pll_cnt_r == PLL_LOCK_REFS);
  end

  // pll reference tick; r32m is divided by four before it reaches the pll
  always_comb begin
    case (pll_ref_r)
      CSG_REF_RC2M:  ref_tick = i_osc_tick[B_RC2M];
      CSG_REF_R32M4: ref_tick = i_osc_tick[B_R32M] && (r32m_div_r == 2'h3);
      CSG_REF_XTAL:  ref_tick = i_osc_tick[B_XOSC];
      CSG_REF_EXTCK: ref_tick = i_osc_tick[B_XOSC];
      default:       ref_tick = 1'b0;
    endcase
  end

  // system clock mux
  always_comb begin
    case (sys_sel_r)
      CSG_SRC_RC2M:  sys_tick = i_osc_tick[B_RC2M];
      CSG_SRC_RC32K: sys_tick = i_osc_tick[B_RC32K];
      CSG_SRC_R32M:  sys_tick = i_osc_tick[B_R32M];
      CSG_SRC_XOSC:  sys_tick = i_osc_tick[B_XOSC];
      CSG_SRC_PLL:   sys_tick = i_pll_tick;
      default:       sys_tick = 1'b0;
    endcase
    sys_tick = sys_tick && !stop_all;
  end

  // signature window: opens for a few cycles, closed by the first protected write
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ccp_cnt_r <= 3'h0;
    end else if (i_clk_en) begin
      if (wr_en && hit(bus.addr, OFF_CHG_PROT) && bus.wdata == CCP_SIGNATURE) begin
        ccp_cnt_r <= CCP_OPEN_CYC;
      end else if (wr_prot && (hit(bus.addr, OFF_SYS_SEL) || hit(bus.addr, OFF_PRESCALE) ||
                   hit(bus.addr, OFF_LOCK) || hit(bus.addr, OFF_FAIL_DET))) begin
        ccp_cnt_r <= 3'h0;
      end else if (ccp_cnt_r != 3'h0) begin
        ccp_cnt_r <= ccp_cnt_r - 3'h1;
      end
    end
  end

  // oscillator enables and crystal mode; failure forces rc2m on and the crystal off
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      osc_en_r     <= RST_OSCILLATOR_CONTROL_REGISTER;
      watch_mode_r <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_en && hit(bus.addr, OFF_OSCILLATOR_CONTROL_REGISTER)) begin
        osc_en_r <= bus.wdata[4:0];
        if (sys_sel_r != CSG_SRC_RC2M || bus.wdata[B_RC2M]) begin
          osc_en_r[B_RC2M] <= bus.wdata[B_RC2M];
        end else begin
          osc_en_r[B_RC2M] <= 1'b1;                                      // running source stays on
        end
      end
      if (wr_en && hit(bus.addr, OFF_XOSC_CTRL) && !osc_en_r[B_XOSC]) begin
        watch_mode_r <= bus.wdata[0];
      end
      if (fail_evt) begin
        osc_en_r[B_XOSC] <= 1'b0;
        osc_en_r[B_RC2M] <= 1'b1;
      end
    end
  end

  // pll configuration, only while the pll is off
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pll_multiply_factor_r <= RST_PLL_MULTIPLY_FACTOR;
      pll_ref_r <= CSG_REF_RC2M;
    end else if (i_clk_en && wr_en && hit(bus.addr, OFF_PLL_CTRL) && !osc_en_r[B_PLL]) begin
      if (bus.wdata[4:0] >= PLL_MULTIPLY_FACTOR_MIN && bus.wdata[4:0] <= PLL_MULTIPLY_FACTOR_MAX) begin
        pll_multiply_factor_r <= bus.wdata[4:0];
      end
      if (!(watch_mode_r && bus.wdata[7] == 1'b1)) begin
        pll_ref_r <= csg_pll_ref_t'(bus.wdata[7:6]);
      end
    end
  end

  // pll stabilisation count in reference cycles
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pll_cnt_r  <= 7'h00;
      r32m_div_r <= 2'h0;
    end else if (i_clk_en) begin
      if (i_osc_tick[B_R32M]) begin
        r32m_div_r <= r32m_div_r + 2'h1;
      end
      if (!osc_en_r[B_PLL] || stop_all || (watch_mode_r && pll_ref_r[1])) begin
        pll_cnt_r <= 7'h00;
      end else if (ref_tick && pll_cnt_r != PLL_LOCK_REFS) begin
        pll_cnt_r <= pll_cnt_r + 7'h01;
      end
    end
  end

  // system source select, lock and fail detector enable; failure takes priority
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sys_sel_r <= CSG_SRC_RC2M;
      lock_r    <= 1'b0;
      fd_en_r   <= 1'b0;
      psa_req_r <= RST_PSA;
      pbc_req_r <= RST_PBC;
    end else if (i_clk_en) begin
      if (wr_prot && !lock_r && hit(bus.addr, OFF_SYS_SEL) && bus.wdata[2:0] <= 3'h4 &&
          osc_rdy[bus.wdata[2:0]]) begin
        sys_sel_r <= csg_sys_src_t'(bus.wdata[2:0]);
      end
      if (wr_prot && !lock_r && hit(bus.addr, OFF_PRESCALE)) begin
        psa_req_r <= (bus.wdata[5:2] > PSA_MAX_CODE) ? PSA_MAX_CODE : bus.wdata[5:2];
        pbc_req_r <= bus.wdata[1:0];
      end
      if (wr_prot && hit(bus.addr, OFF_LOCK) && bus.wdata[0]) begin
        lock_r <= 1'b1;
      end
      if (wr_prot && hit(bus.addr, OFF_FAIL_DET) && bus.wdata[B_FD_EN]) begin
        fd_en_r <= 1'b1;
      end
      if (fail_evt) begin
        lock_r <= 1'b0;
        if (sys_sel_r == CSG_SRC_XOSC) begin
          sys_sel_r <= CSG_SRC_RC2M;
        end
      end
    end
  end

  // failure monitor: no crystal edge over two ulp periods means below 32 khz
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      fd_miss_r <= 2'h0;
      fd_seen_r <= 1'b0;
      fd_flag_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!fd_en_r || !osc_en_r[B_XOSC] || fail_evt) begin
        fd_miss_r <= 2'h0;
        fd_seen_r <= 1'b0;
      end else if (i_ulp_tick) begin
        fd_miss_r <= fd_seen_r ? 2'h0 : fd_miss_r + 2'h1;
        fd_seen_r <= i_osc_tick[B_XOSC];
      end else if (i_osc_tick[B_XOSC]) begin
        fd_seen_r <= 1'b1;
      end
      // set wins over a write-one clear in the same cycle
      if (fail_evt) begin
        fd_flag_r <= 1'b1;
      end else if (wr_en && hit(bus.addr, OFF_FAIL_DET) && bus.wdata[B_FD_FLAG]) begin
        fd_flag_r <= 1'b0;
      end
    end
  end

  // prescalers: new settings are only taken at the end of a whole output period
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      psa_act_r  <= RST_PSA;
      pbc_act_r  <= RST_PBC;
      pa_cnt_r   <= 9'h000;
      bc_cnt_r   <= 2'h0;
      bus.ce_4x  <= 1'b0;
      bus.ce_2x  <= 1'b0;
      bus.ce_cpu <= 1'b0;
    end else if (i_clk_en) begin
      bus.ce_4x  <= 1'b0;
      bus.ce_2x  <= 1'b0;
      bus.ce_cpu <= 1'b0;
      if (sys_tick) begin
        if (pa_cnt_r >= psa_last(psa_act_r)) begin
          pa_cnt_r  <= 9'h000;
          psa_act_r <= psa_req_r;
          bus.ce_4x <= 1'b1;
          bc_cnt_r  <= bc_cnt_r + 2'h1;
          // pbc: 00 1/1, 01 b1 c2, 10 b4 c1, 11 b2 c2
          case (pbc_act_r)
            2'h0: begin
              bus.ce_2x  <= 1'b1;
              bus.ce_cpu <= 1'b1;
            end
            2'h1: begin
              bus.ce_2x  <= 1'b1;
              bus.ce_cpu <= bc_cnt_r[0];
            end
            2'h2: begin
              bus.ce_2x  <= (bc_cnt_r == 2'h3);
              bus.ce_cpu <= (bc_cnt_r == 2'h3);
            end
            default: begin
              bus.ce_2x  <= bc_cnt_r[0];
              bus.ce_cpu <= (bc_cnt_r == 2'h3);
            end
          endcase
          if (bc_cnt_r == 2'h3) begin
            pbc_act_r <= pbc_req_r;
          end
        end else begin
          pa_cnt_r <= pa_cnt_r + 9'h001;
        end
      end
    end
  end

  // register read, nmi pulse and analog run enables
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      bus.rdata    <= 8'h00;
      bus.nmi      <= 1'b0;
      o_osc_run    <= 5'h00;
      o_pll_factor <= RST_PLL_MULTIPLY_FACTOR;
    end else if (i_clk_en) begin
      bus.nmi      <= fail_evt;
      o_pll_factor <= pll_multiply_factor_r;
      o_osc_run    <= osc_en_r;
      if (stop_all) begin
        o_osc_run <= 5'h00;
        o_osc_run[B_RC32K] <= osc_en_r[B_RC32K] && i_rtc_en &&
                              (i_sleep_mode == CSG_SLP_PWRSAVE);
      end
      bus.rdata <= 8'h00;
      if (bus.rd) begin
        case (bus.addr)
          OFF_OSCILLATOR_CONTROL_REGISTER:   bus.rdata <= {3'h0, osc_en_r};
          OFF_OSCILLATOR_STATUS_REGISTER: bus.rdata <= {3'h0, osc_rdy};
          OFF_XOSC_CTRL:  bus.rdata <= {7'h00, watch_mode_r};
          OFF_FAIL_DET:   bus.rdata <= {6'h00, fd_flag_r, fd_en_r};
          OFF_PLL_CTRL:   bus.rdata <= {pll_ref_r, 1'b0, pll_multiply_factor_r};
          OFF_SYS_SEL:    bus.rdata <= {5'h00, sys_sel_r};
          OFF_PRESCALE:   bus.rdata <= {2'h0, psa_req_r, pbc_req_r};
          OFF_LOCK:       bus.rdata <= {7'h00, lock_r};
          default:        bus.rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ===== verilog/csg_cpu_side.sv
// csg_cpu_side: cpu end; forwards software register accesses and masks interrupts after a signature
// assumes software port: one-cycle strobes, read data in the following cycle
`timescale 1ns/1ps
module csg_cpu_side (
  // clock, reset, enable
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  // software port
  input  wire logic [7:0] i_sw_addr,
  input  wire logic [7:0] i_sw_wdata,
  input  wire logic       i_sw_wr,
  input  wire logic       i_sw_rd,
  output logic      [7:0] o_sw_rdata,
  // cpu status
  output logic            o_int_block,
  output logic            o_nmi_pend,
  // clock generator side
  csg_if.host             bus
);
  import csg_pkg::*;

  logic [2:0] blk_cnt_r;
  logic       local_rd_r;
  logic [7:0] local_q_r;

  // requests pass straight through so device read data lands in the next cycle
  assign bus.addr  = i_sw_addr;
  assign bus.wdata = i_sw_wdata;
  assign bus.wr    = i_sw_wr && (i_sw_addr != OFF_HOST_STAT);
  assign bus.rd    = i_sw_rd && (i_sw_addr != OFF_HOST_STAT);
  // both sources are flops; select is a flop too
  assign o_sw_rdata = local_rd_r ? local_q_r : bus.rdata;

  // interrupt mask for four cpu ticks after the signature write
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      blk_cnt_r   <= 3'h0;
      o_int_block <= 1'b0;
    end else if (i_clk_en) begin
      if (i_sw_wr && i_sw_addr == OFF_CHG_PROT && i_sw_wdata == CCP_SIGNATURE) begin
        blk_cnt_r   <= INT_BLOCK_CPU;
        o_int_block <= 1'b1;
      end else if (bus.ce_cpu && blk_cnt_r != 3'h0) begin
        blk_cnt_r   <= blk_cnt_r - 3'h1;
        o_int_block <= (blk_cnt_r != 3'h1);
      end
    end
  end

  // sticky nmi pending, write one clears, a new nmi wins
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_nmi_pend <= 1'b0;
      local_rd_r <= 1'b0;
      local_q_r  <= 8'h00;
    end else if (i_clk_en) begin
      if (bus.nmi) begin
        o_nmi_pend <= 1'b1;
      end else if (i_sw_wr && i_sw_addr == OFF_HOST_STAT && i_sw_wdata[0]) begin
        o_nmi_pend <= 1'b0;
      end
      local_rd_r <= i_sw_rd && (i_sw_addr == OFF_HOST_STAT);
      local_q_r  <= {6'h00, o_int_block, o_nmi_pend};
    end
  end
endmodule

// ===== verilog/csg_if.sv
// csg_if: register port and clock enables between clock generator and the cpu side
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface csg_if;
  logic [7:0] addr;    // register address
  logic [7:0] wdata;   // write data
  logic       wr;      // write strobe
  logic       rd;      // read strobe
  logic [7:0] rdata;   // read data, cycle after rd
  logic       nmi;     // one-cycle failure interrupt
  logic       ce_4x;   // tick at up to four times cpu rate
  logic       ce_2x;   // tick at up to two times cpu rate
  logic       ce_cpu;  // cpu tick
  modport dev  (input addr, wdata, wr, rd, output rdata, nmi, ce_4x, ce_2x, ce_cpu);
  modport host (output addr, wdata, wr, rd, input rdata, nmi, ce_4x, ce_2x, ce_cpu);
endinterface

// ===== verilog/csg_pkg.sv
// csg_pkg: register map, field layout, reset values and counts for the clock generator
// assumes 8-bit register data and one 100 MHz system clock
package csg_pkg;
  // register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_OSCILLATOR_CONTROL_REGISTER   = 8'h00;
  localparam logic [7:0] OFF_OSCILLATOR_STATUS_REGISTER = 8'h01;
  localparam logic [7:0] OFF_XOSC_CTRL  = 8'h02;
  localparam logic [7:0] OFF_FAIL_DET   = 8'h03;
  localparam logic [7:0] OFF_PLL_CTRL   = 8'h05;
  localparam logic [7:0] OFF_CHG_PROT   = 8'h34;
  localparam logic [7:0] OFF_SYS_SEL    = 8'h40;
  localparam logic [7:0] OFF_PRESCALE   = 8'h41;
  localparam logic [7:0] OFF_LOCK       = 8'h42;
  localparam logic [7:0] OFF_HOST_STAT  = 8'hf0;
  // oscillator bit positions in control and status
  localparam int B_RC2M  = 0;
  localparam int B_RC32K = 1;
  localparam int B_R32M  = 2;
  localparam int B_XOSC  = 3;
  localparam int B_PLL   = 4;
  // fail detector register bits
  localparam int B_FD_EN   = 0;
  localparam int B_FD_FLAG = 1;
  // pll control fields
  localparam int PLL_MULTIPLY_FACTOR_LSB = 0;
  localparam int PLL_REFERENCE_SELECT_LSB = 6;
  localparam logic [4:0] PLL_MULTIPLY_FACTOR_MIN = 5'h01;
  localparam logic [4:0] PLL_MULTIPLY_FACTOR_MAX = 5'h1f;
  // reset values
  localparam logic [4:0] RST_OSCILLATOR_CONTROL_REGISTER = 5'h01;
  localparam logic [4:0] RST_PLL_MULTIPLY_FACTOR  = 5'h01;
  localparam logic [3:0] RST_PSA      = 4'h0;
  localparam logic [1:0] RST_PBC      = 2'h0;
  localparam logic [3:0] PSA_MAX_CODE = 4'h9;
  // protection and timing counts
  localparam logic [7:0] CCP_SIGNATURE   = 8'hd8;
  localparam logic [2:0] CCP_OPEN_CYC    = 3'h4;
  localparam logic [2:0] INT_BLOCK_CPU   = 3'h4;
  localparam logic [6:0] PLL_LOCK_REFS   = 7'h40;
  localparam logic [1:0] FD_MISS_LIMIT   = 2'h2;
  // system clock sources
  typedef enum logic [2:0] {
    CSG_SRC_RC2M  = 3'b000,
    CSG_SRC_RC32K = 3'b001,
    CSG_SRC_R32M  = 3'b010,
    CSG_SRC_XOSC  = 3'b011,
    CSG_SRC_PLL   = 3'b100
  } csg_sys_src_t;
  // pll reference inputs
  typedef enum logic [1:0] {
    CSG_REF_RC2M  = 2'b00,
    CSG_REF_R32M4 = 2'b01,
    CSG_REF_XTAL  = 2'b10,
    CSG_REF_EXTCK = 2'b11
  } csg_pll_ref_t;
  // sleep modes
  typedef enum logic [2:0] {
    CSG_SLP_ACTIVE  = 3'b000,
    CSG_SLP_IDLE    = 3'b001,
    CSG_SLP_PWRDOWN = 3'b010,
    CSG_SLP_PWRSAVE = 3'b011,
    CSG_SLP_STANDBY = 3'b100,
    CSG_SLP_EXTSTBY = 3'b101
  } csg_sleep_t;
endpackage
